// ==== logic/fdc_param_defines.svh ====
`ifndef FDC_PARAM_DEFINES_SVH
`define FDC_PARAM_DEFINES_SVH
// Register byte addresses
`define A_CTRL      8'h00
`define A_GEOM      8'h04
`define A_SEEK      8'h08
`define A_CFG       8'h0C
`define A_STATUS    8'h10
`define A_RESULT    8'h14
`define A_DATA      8'h18
// CTRL fields
`define CTRL_OP     2:0
`define CTRL_NODMA  3
`define CTRL_SKIP   4
`define CTRL_COUNT  5
`define CTRL_GO     31
// GEOM fields
`define GEOM_N      2:0
`define GEOM_SHORT  15:8
`define GEOM_R      23:16
`define GEOM_TRACK  31:24
// SEEK fields
`define SEEK_TARGET 7:0
`define SEEK_OFFSET 15:8
`define SEEK_DIR    16
// CFG fields
`define CFG_STEP    3:0
`define CFG_POLL    4
`define CFG_EARLY_WE 5
`define CFG_PERP    11:8
`define CFG_PERMIT  12
`define CFG_PRE     23:16
// Bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
// Sizes and timing
`define SECT_BASE   16'h0080
`define N_MAX       3'h7
`define STEP_TOP    5'h10
`define MCLK_NS     8
`define STEP_UNIT_NS 500000
`endif

// ==== logic/fdc_param_pkg.sv ====
package fdc_param_pkg;
   typedef enum logic [2:0] {
      OP_READ, OP_READ_DEL, OP_WRITE, OP_FORMAT,
      OP_VERIFY, OP_SEEK_ABS, OP_SEEK_REL, OP_SENSE
   } op_t;
   typedef enum {S_IDLE, S_SEEK, S_SECT, S_BYTES, S_DONE} state_t;
endpackage

// ==== logic/fdc_command_params.sv ====
// Functional notes
// - Size code zero: 128-byte sector, bytes moved set by short_sector_length.
// - Nonzero code: size is 128 shifted left by code, codes up to 7.
// - no_dma_flag 1: every data byte raises a host interrupt.
// - no_dma_flag 0: every byte raises dma_request, served by dma_acknowledge_n.
// - Perpendicular bits 3:0 change only when overwrite_permit in same write.
// - Sense-interrupt result holds the current cylinder.
// - Poll disable set stops drive polling; clear lets it run.
// - Precompensation applies from precomp_start_track 00..FF onward.
// - Multi-sector transfers start at the given first sector.
// - Relative seek moves by offset from current cylinder.
// - Absolute seek steps to target_cylinder.
// - Format initialises exactly track_sectors sectors.
// - Verify with verify_by_count covers track_sectors sectors.
// - Bypass on read skips sectors with deleted mark.
// - Bypass on read-deleted accesses only deleted-mark sectors.
// - Bypass clear: no sector is skipped.
// - Step pulses spaced 0.5 to 8 ms in 0.5 ms steps.
// - Four result bytes held for reading after each command.
// - Write-gate option raises write enable early for pre-erase.
// - Size code zero on write: bytes past short length written as zero.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "fdc_param_defines.svh"
module fdc_command_params
   import fdc_param_pkg::*;
#(
   parameter int STEP_UNIT_CYC = `STEP_UNIT_NS / `MCLK_NS
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Drive sequencing side
   input  wire logic        sector_start,
   input  wire logic        deleted_mark,
   input  wire logic        byte_tick,
   output logic             step_pulse,
   output logic             step_dir,
   output logic             write_enable,
   output logic             precomp_en,
   output logic             fill_zero,
   output logic             poll_active,
   // Host transfer side
   output logic             dma_request,
   input  wire logic        dma_acknowledge_n,
   output logic             data_irq
);

   // Sector length in bytes for a size code
   function automatic logic [15:0] sect_len(input logic [2:0] n);
      sect_len = `SECT_BASE << n;
   endfunction

   // Software-written registers
   logic [31:0] ctrl_r, geom_r, seek_r, cfg_r;
   logic [3:0]  perp_r;
   // Latched command copies
   logic [2:0]  op_r, n_r;
   logic        nodma_r, skip_r, early_we_r;
   logic [7:0]  short_len_r, pre_r;
   // Execution state
   state_t      state_r;
   logic [7:0]  cyl_r, tgt_r, sect_r, left_r;
   logic [15:0] idx_r, phys_r, xfer_r;
   logic [19:0] stept_r;
   logic [31:0] result_r;
   logic        busy_r;
   // Bus state
   logic        aw_have_r, w_have_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic        wr_fire, go;
   logic [19:0] step_cyc;
   logic        is_wr_op;

   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
   assign go = wr_fire && aw_addr_r == `A_CTRL && w_data_r[`CTRL_GO] && !busy_r;
   assign is_wr_op = op_r == OP_WRITE || op_r == OP_FORMAT;
   // Step spacing: code 0 gives 8 ms, code F gives 0.5 ms
   assign step_cyc = 20'((`STEP_TOP - {1'b0, cfg_r[`CFG_STEP]}) * STEP_UNIT_CYC);

   // Write address and data accepted independently
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
         end
         if (wr_fire)
         begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r <= `A_DATA && aw_addr_r[1:0] == 2'h0) ?
                            `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Register writes; strobes ignored for brevity of full-word fields
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_r <= 32'h0;
         geom_r <= 32'h0;
         seek_r <= 32'h0;
         cfg_r  <= 32'h0;
         perp_r <= 4'h0;
      end
      else if (wr_fire)
      begin
         unique case (aw_addr_r)
            `A_CTRL: ctrl_r <= w_data_r;
            `A_GEOM: geom_r <= w_data_r;
            `A_SEEK: seek_r <= w_data_r;
            `A_CFG:
            begin
               cfg_r <= w_data_r;
               if (w_data_r[`CFG_PERMIT])
                  perp_r <= w_data_r[`CFG_PERP];
            end
            default: ;
         endcase
      end
   end

   // Read channel; reading DATA services a per-byte interrupt
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            unique case (s_axi_araddr)
               `A_CTRL:   s_axi_rdata <= {1'b0, ctrl_r[30:0]};
               `A_GEOM:   s_axi_rdata <= geom_r;
               `A_SEEK:   s_axi_rdata <= seek_r;
               `A_CFG:    s_axi_rdata <= {cfg_r[31:12], perp_r, cfg_r[7:0]};
               `A_STATUS: s_axi_rdata <= {8'h00, sect_r, cyl_r, 7'h00, busy_r};
               `A_RESULT: s_axi_rdata <= result_r;
               `A_DATA:   s_axi_rdata <= {16'h0000, idx_r};
               default:
               begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Parameters frozen when a command starts
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         op_r    <= 3'h0;
         n_r     <= 3'h0;
         nodma_r <= 1'b0;
         skip_r  <= 1'b0;
         early_we_r  <= 1'b0;
         short_len_r <= 8'h00;
         pre_r   <= 8'h00;
      end
      else if (go)
      begin
         op_r    <= w_data_r[`CTRL_OP];
         nodma_r <= w_data_r[`CTRL_NODMA];
         skip_r  <= w_data_r[`CTRL_SKIP];
         n_r     <= geom_r[`GEOM_N];
         short_len_r <= geom_r[`GEOM_SHORT];
         pre_r   <= cfg_r[`CFG_PRE];
         early_we_r  <= cfg_r[`CFG_EARLY_WE];
      end
   end

   // Command sequencer
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r    <= S_IDLE;
         busy_r     <= 1'b0;
         cyl_r      <= 8'h00;
         tgt_r      <= 8'h00;
         sect_r     <= 8'h00;
         left_r     <= 8'h00;
         idx_r      <= 16'h0;
         phys_r     <= 16'h0;
         xfer_r     <= 16'h0;
         stept_r    <= 20'h0;
         result_r   <= 32'h0;
         step_pulse <= 1'b0;
         step_dir   <= 1'b0;
      end
      else
      begin
         step_pulse <= 1'b0;
         unique case (state_r)
            S_IDLE:
               if (go)
               begin
                  busy_r <= 1'b1;
                  sect_r <= geom_r[`GEOM_R];
                  phys_r <= sect_len(geom_r[`GEOM_N]);
                  xfer_r <= (geom_r[`GEOM_N] == 3'h0) ?
                            {8'h00, geom_r[`GEOM_SHORT]} : sect_len(geom_r[`GEOM_N]);
                  stept_r <= 20'h0;
                  unique case (op_t'(w_data_r[`CTRL_OP]))
                     OP_SEEK_ABS:
                     begin
                        tgt_r   <= seek_r[`SEEK_TARGET];
                        state_r <= S_SEEK;
                     end
                     OP_SEEK_REL:
                     begin
                        tgt_r   <= seek_r[`SEEK_DIR] ? cyl_r - seek_r[`SEEK_OFFSET] :
                                   cyl_r + seek_r[`SEEK_OFFSET];
                        state_r <= S_SEEK;
                     end
                     OP_SENSE:
                     begin
                        result_r <= {24'h0, cyl_r};
                        state_r  <= S_DONE;
                     end
                     OP_FORMAT:
                     begin
                        left_r  <= geom_r[`GEOM_TRACK];
                        state_r <= S_SECT;
                     end
                     OP_VERIFY:
                     begin
                        left_r  <= w_data_r[`CTRL_COUNT] ? geom_r[`GEOM_TRACK] : 8'h01;
                        state_r <= S_SECT;
                     end
                     default:
                     begin
                        left_r  <= geom_r[`GEOM_TRACK] - geom_r[`GEOM_R] + 8'h01;
                        state_r <= S_SECT;
                     end
                  endcase
               end
            S_SEEK:
               if (cyl_r == tgt_r)
               begin
                  result_r <= {24'h0, cyl_r};
                  state_r  <= S_DONE;
               end
               else if (stept_r >= step_cyc - 20'h1)
               begin
                  stept_r    <= 20'h0;
                  step_pulse <= 1'b1;
                  step_dir   <= tgt_r > cyl_r;
                  cyl_r      <= (tgt_r > cyl_r) ? cyl_r + 8'h01 : cyl_r - 8'h01;
               end
               else
                  stept_r <= stept_r + 20'h1;
            S_SECT:
               if (left_r == 8'h00)
                  state_r <= S_DONE;
               else if (sector_start)
               begin
                  idx_r <= 16'h0;
                  // Skip sectors that the bypass flag excludes
                  if (skip_r && ((op_r == OP_READ && deleted_mark) ||
                      (op_r == OP_READ_DEL && !deleted_mark)))
                     sect_r <= sect_r + 8'h01;
                  else
                     state_r <= S_BYTES;
               end
            S_BYTES:
               if (byte_tick)
               begin
                  idx_r <= idx_r + 16'h1;
                  if (idx_r == phys_r - 16'h1)
                  begin
                     sect_r  <= sect_r + 8'h01;
                     left_r  <= left_r - 8'h01;
                     state_r <= S_SECT;
                  end
               end
            S_DONE:
            begin
               result_r[31:8] <= {5'h00, op_r, sect_r, 8'h00};
               busy_r  <= 1'b0;
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // Per-byte host service: DMA request or interrupt
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dma_request <= 1'b0;
         data_irq    <= 1'b0;
      end
      else
      begin
         if (state_r == S_BYTES && byte_tick && idx_r < xfer_r && op_r != OP_VERIFY &&
             op_r != OP_FORMAT)
         begin
            if (nodma_r)
               data_irq <= 1'b1;
            else
               dma_request <= 1'b1;
         end
         else
         begin
            if (!dma_acknowledge_n)
               dma_request <= 1'b0;
            if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `A_DATA)
               data_irq <= 1'b0;
         end
      end
   end

   // Drive-facing levels
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         write_enable <= 1'b0;
         precomp_en   <= 1'b0;
         fill_zero    <= 1'b0;
         poll_active  <= 1'b0;
      end
      else
      begin
         write_enable <= is_wr_op && (state_r == S_BYTES ||
                         (early_we_r && state_r == S_SECT));
         precomp_en   <= is_wr_op && busy_r && cyl_r >= pre_r;
         fill_zero    <= op_r == OP_WRITE && state_r == S_BYTES &&
                         n_r == 3'h0 && idx_r >= {8'h00, short_len_r};
         poll_active  <= !cfg_r[`CFG_POLL] && state_r == S_IDLE;
      end
   end

endmodule // fdc_command_params

// ==== testbench/fdc_command_params_chk.sv ====
`timescale 1ns/10ps
module fdc_command_params_chk #(
   parameter int STEP_UNIT_CYC = 4
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Drive and host transfer
   input wire logic byte_tick,
   input wire logic step_pulse,
   input wire logic write_enable,
   input wire logic fill_zero,
   input wire logic poll_active,
   input wire logic dma_request,
   input wire logic dma_acknowledge_n,
   input wire logic data_irq
);
   int gap_r;
   // Cycles since the last step pulse, saturating
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         gap_r <= 1 << 20;
      else if (step_pulse)
         gap_r <= 1;
      else if (gap_r < (1 << 20))
         gap_r <= gap_r + 1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Bus transfers taken
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_step_gap;
      step_pulse |-> gap_r >= STEP_UNIT_CYC;
   endproperty
   property p_wr_resp;
      s_wr |-> ##[1:2] s_axi_bvalid;
   endproperty
   property p_rd_resp;
      s_rd |-> ##[1:2] s_axi_rvalid;
   endproperty
   property p_dma_clr;
      dma_request && !dma_acknowledge_n && !byte_tick |=> !dma_request;
   endproperty
   property p_dma_rise;
      $rose(dma_request) |-> $past(byte_tick) || $past(byte_tick, 2);
   endproperty
   property p_irq_rise;
      $rose(data_irq) |-> $past(byte_tick) || $past(byte_tick, 2);
   endproperty
   property p_irq_clr;
      $fell(data_irq) |-> $past(s_axi_arready) || $past(s_axi_arready, 2);
   endproperty
   property p_mode;
      data_irq |-> !dma_request;
   endproperty
   property p_fz_we;
      fill_zero |-> write_enable;
   endproperty
   property p_poll;
      poll_active |-> !write_enable && !fill_zero;
   endproperty
   a_step_gap: assert property (p_step_gap)
      else $error("step pulses too close");
   a_wr_resp: assert property (p_wr_resp)
      else $error("no write response");
   a_rd_resp: assert property (p_rd_resp)
      else $error("no read data");
   a_dma_clr: assert property (p_dma_clr)
      else $error("request kept after acknowledge");
   a_dma_rise: assert property (p_dma_rise)
      else $error("request without byte");
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt without byte");
   a_irq_clr: assert property (p_irq_clr)
      else $error("interrupt cleared without read");
   a_mode: assert property (p_mode)
      else $error("interrupt and request together");
   a_fz_we: assert property (p_fz_we)
      else $error("zero fill outside write");
   a_poll: assert property (p_poll)
      else $error("polling while writing");
endmodule // fdc_command_params_chk
bind fdc_command_params fdc_command_params_chk
   #(.STEP_UNIT_CYC(STEP_UNIT_CYC)) u_chk (.*);

// ==== testbench/dma_host_model.sv ====
`timescale 1ns/10ps
module dma_host_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Request side
   input wire logic dma_request,
   input wire logic slow,
   output logic     dma_acknowledge_n,
   output int       acks
);
   int wait_r;
   // Serve each request by a one-cycle acknowledge, slow adds delay
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dma_acknowledge_n <= 1'b1;
         wait_r <= 0;
         acks <= 0;
      end
      else if (!dma_acknowledge_n)
      begin
         dma_acknowledge_n <= 1'b1;
         acks <= acks + 1;
      end
      else if (dma_request && wait_r >= (slow ? 3 : 0))
      begin
         dma_acknowledge_n <= 1'b0;
         wait_r <= 0;
      end
      else if (dma_request)
         wait_r <= wait_r + 1;
   end
endmodule // dma_host_model

// ==== testbench/fdc_command_params_bench.sv ====
`timescale 1ns/10ps
`include "fdc_param_defines.svh"
module fdc_command_params_bench;
   // Design ports and bench state
   logic        mclk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, slow = 0;
   logic        sector_start = 0, deleted_mark = 0, byte_tick = 0, dq, fz, pc;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, step_pulse, step_dir, write_enable, precomp_en;
   logic        fill_zero, poll_active, dma_request, dma_acknowledge_n;
   logic        data_irq, we_pre, dir_s;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   int          errors, num_checks, acks, irqs, steps, gap, cyc, tn;
   fdc_command_params #(.STEP_UNIT_CYC(4)) u_dut (.*);
   dma_host_model u_dma (.mclk(mclk), .arst_n(arst_n), .dma_request(dma_request),
      .slow(slow), .dma_acknowledge_n(dma_acknowledge_n), .acks(acks));
   // Clock
   always #4 mclk = ~mclk;
   // Record drive-side activity and host interrupt rises
   always @(posedge mclk)
   begin
      if (fill_zero)
         fz <= 1'b1;
      if (precomp_en)
         pc <= 1'b1;
      if (data_irq && !dq)
         irqs <= irqs + 1;
      dq <= data_irq;
      cyc <= step_pulse ? 1 : cyc + 1;
      if (step_pulse)
      begin
         steps <= steps + 1;
         gap <= cyc;
         dir_s <= step_dir;
      end
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Bus write, response code left in r
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Bus read, data in d and response in r
   task automatic rd(logic [7:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rst();
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      fz = 0;
      pc = 0;
      irqs = 0;
      steps = 0;
   endtask
   task automatic idle();
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 9000 && !poll_active; i++)
         @(posedge mclk);
   endtask
   // Start a command and play the drive for up to 8 sectors or until the block goes idle
   task automatic run(logic [31:0] ctl, cfg, geo, logic del, int es, ea);
      int s;
      rst();
      wr(`A_CFG, cfg);
      wr(`A_GEOM, geo);
      wr(`A_CTRL, ctl | 32'h8000_0000);
      wr(`A_GEOM, 0);
      repeat (4) @(posedge mclk);
      we_pre = write_enable;
      for (s = 0; s < 8 && !poll_active; s++)
      begin
         sector_start <= 1'b1;
         deleted_mark <= del;
         @(posedge mclk);
         sector_start <= 1'b0;
         repeat (128 << geo[2:0])
         begin
            repeat (6) @(posedge mclk);
            if (data_irq)
               rd(`A_DATA);
            if (poll_active)
               break;
            byte_tick <= 1'b1;
            @(posedge mclk);
            byte_tick <= 1'b0;
         end
         repeat (6) @(posedge mclk);
      end
      if (es >= 0)
         chk("sectors", es, s);
      if (ea >= 0)
         chk("dma acks", ea, acks);
      $display("test %0d done", ++tn);
   endtask
   initial
   begin
      rst();
      wr(`A_CFG, 32'h0000_1500);
      wr(`A_CFG, 32'h00FF_0A10);
      repeat (3) @(posedge mclk);
      chk("poll off", 0, poll_active);
      rd(`A_CFG);
      chk("cfg", 32'h00FF_0510, d & 32'h00FF_0F1F);
      wr(8'h1C, 0);
      chk("wr unmapped", `RESP_SLVERR, r);
      rd(8'h1C);
      chk("rd unmapped data", 0, d);
      chk("rd unmapped", `RESP_SLVERR, r);
      wr(`A_CFG, 32'h0000_000E);
      repeat (3) @(posedge mclk);
      chk("poll on", 1, poll_active);
      wr(`A_SEEK, 32'h0000_0003);
      wr(`A_CTRL, 32'h8000_0005);
      idle();
      chk("steps", 3, steps);
      chk("step gap", 8, gap);
      chk("step dir", 1, dir_s);
      rd(`A_STATUS);
      chk("cylinder", 3, d[15:8]);
      wr(`A_SEEK, 32'h0001_0200);
      wr(`A_CTRL, 32'h8000_0006);
      idle();
      chk("rel dir", 0, dir_s);
      rd(`A_STATUS);
      chk("rel cylinder", 1, d[15:8]);
      wr(`A_CTRL, 32'h8000_0007);
      idle();
      rd(`A_RESULT);
      chk("sense cylinder", 1, d[7:0]);
      $display("test %0d done", ++tn);
      run(0, 0, 32'h0302_0400, 0, 2, 8);
      slow = 1;
      run(0, 0, 32'h0101_FF01, 0, 1, 256);
      run(32'h10, 0, 32'h0101_0400, 1, -1, 0);
      run(32'h11, 0, 32'h0101_0400, 0, -1, 0);
      run(0, 0, 32'h0101_0400, 1, 1, 4);
      run(3, 0, 32'h0301_0400, 0, 3, -1);
      run(32'h24, 0, 32'h0201_0400, 0, 2, -1);
      run(4, 0, 32'h0201_0400, 0, 1, -1);
      run(8, 0, 32'h0101_0400, 0, 1, 0);
      chk("irqs", 4, irqs);
      run(2, 32'h20, 32'h0101_0400, 0, 1, 4);
      chk("fill zero", 1, fz);
      chk("precomp", 1, pc);
      chk("early gate", 1, we_pre);
      run(2, 32'h00FF_0000, 32'h0101_0400, 0, 1, 4);
      chk("no precomp", 0, pc);
      chk("no early gate", 0, we_pre);
      end_of_test();
   end
   // Watchdog
   initial
   begin
      repeat (80000) @(posedge mclk);
      errors++;
      end_of_test();
   end
endmodule // fdc_command_params_bench
